// ### verilog/ths_pkg.sv
// constants of the touch host status register bank
// Overview of operation
// - interrupt bit 6 sets when a nonvolatile burn finishes
// - interrupt bit 5 sets when a shadow memory write takes effect
// - interrupt bit 2 sets on touch/close, or release/far when enabled
// - interrupt bit 1 sets when offset compensation completes, any trigger
// - interrupt bit 0 sets only on entering Active/Doze after host request
// - interrupt pin is low while any interrupt flag is set
// - interrupt flags accumulate independently until cleared
// - reading the interrupt register clears all flags and releases the pin
// - a flag may lag its event by up to one scan period
// - interrupt bits 7, 4 and 3 are reserved and never set
// - status bit 7 is proximity, 1 for close
// - status bit 6 is the priority key, 1 for touched
// - status bits 5:0 hold matrix key number, 0 none, 1 to 36
// - with several keys touched only the first touched one is reported
// - memory status bit 3 shows nonvolatile parameters in use, 7:4 reserved
// - register map: status 0x00/01/08, control 0x09-0x0e, keys 0xac/ad, restart 0xb1
// - answers as a serial bus slave at 7-bit address 0x2b
// - register address increments after each data byte
// - mode field 1:0 is 00 Active, 01 Doze, 10 Sleep, 11 reserved
package ths_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h2b;
    localparam logic [3:0] BIT_COUNT = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [7:0] ADDR_IRQ_SRC = 8'h00;
    localparam logic [7:0] ADDR_TOUCH_STAT = 8'h01;
    localparam logic [7:0] ADDR_PMEM_STAT = 8'h08;
    localparam logic [7:0] ADDR_COMP_MODE = 8'h09;
    localparam logic [7:0] ADDR_GPO_CTRL = 8'h0a;
    localparam logic [7:0] ADDR_GW_CFG = 8'h0d;
    localparam logic [7:0] ADDR_GW_BASE = 8'h0e;
    localparam logic [7:0] ADDR_KEY_HIGH = 8'hac;
    localparam logic [7:0] ADDR_KEY_LOW = 8'had;
    localparam logic [7:0] ADDR_RESTART = 8'hb1;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int IRQ_MODE_BIT = 0;
    localparam int IRQ_COMP_BIT = 1;
    localparam int IRQ_SENSE_BIT = 2;
    localparam int IRQ_SPMW_BIT = 5;
    localparam int IRQ_BURN_BIT = 6;
    localparam logic [7:0] IRQ_USED_MASK = 8'h67;
    localparam int PROX_BIT = 7;
    localparam int PRIO_BIT = 6;
    localparam int KEY_COUNT = 36;
    localparam logic [5:0] KEY_NONE = 6'h00;
    localparam logic [5:0] KEY_ONE = 6'h01;
    localparam logic [7:0] PMEM_NVM_VALID = 8'h08;
    localparam int COMP_BIT = 2;
    localparam logic [1:0] MODE_ACTIVE = 2'h0;
    localparam logic [1:0] MODE_DOZE = 2'h1;
    localparam logic [1:0] MODE_SLEEP = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;
    localparam logic [7:0] GW_CFG_MASK = 8'h38;
    localparam logic [7:0] GW_BASE_MASK = 8'h78;
    localparam logic [7:0] RESTART_ARM = 8'hde;
    localparam logic [7:0] RESTART_FIRE = 8'h00;
endpackage

// ### verilog/ths_i2c_slave.sv
// serial bus slave byte engine with auto-incrementing register pointer
`timescale 1ns/100ps
module ths_i2c_slave
    import ths_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // register access
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data
);
    typedef enum logic [6:0]
    {
        ST_IDLE = 7'h01,
        ST_DEV = 7'h02,
        ST_DACK = 7'h04,
        ST_RX = 7'h08,
        ST_RACK = 7'h10,
        ST_TX = 7'h20,
        ST_MACK = 7'h40
    } ths_i2c_st_t;

    ths_i2c_st_t st_r, st_nxt;
    logic scl_q_r, sda_q_r, rw_r, rw_nxt, first_r, first_nxt, nack_r, nack_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt;

    wire start_w = scl_in & scl_q_r & sda_q_r & ~sda_in;
    wire stop_w = scl_in & scl_q_r & ~sda_q_r & sda_in;
    wire rise_w = scl_in & ~scl_q_r;
    wire fall_w = ~scl_in & scl_q_r;
    wire done_w = fall_w & (cnt_r == BIT_COUNT);
    wire hit_w = (sh_r[7:1] == SLAVE_ADDR);
    wire fetch_w = ((st_r == ST_DACK) & rw_r | (st_r == ST_MACK) & ~nack_r) & fall_w;
    wire store_w = (st_r == ST_RX) & done_w & ~first_r;
    wire [7:0] ptr_inc_w = ptr_r + 8'h01;

    assign rd_en = ce & fetch_w;
    assign wr_en = ce & store_w;
    assign reg_addr = ptr_r;
    assign wr_data = sh_r;
    assign sda_out = 1'b0;
    assign sda_oe = (st_r == ST_DACK) | (st_r == ST_RACK) | ((st_r == ST_TX) & ~tx_r[7]);

    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        ptr_nxt = ptr_r;
        rw_nxt = rw_r;
        first_nxt = first_r;
        nack_nxt = nack_r;
        if (rise_w)
        begin
            cnt_nxt = cnt_r + 4'h1;
            sh_nxt = {sh_r[6:0], sda_in};
        end
        unique case (st_r)
            ST_IDLE: ;
            ST_DEV:
                if (done_w)
                begin
                    st_nxt = hit_w ? ST_DACK : ST_IDLE;
                    rw_nxt = sh_r[0];
                end
            ST_DACK:
                if (fall_w)
                begin
                    cnt_nxt = CNT_ZERO;
                    st_nxt = rw_r ? ST_TX : ST_RX;
                    first_nxt = ~rw_r;
                end
            ST_RX:
                if (done_w)
                begin
                    st_nxt = ST_RACK;
                    first_nxt = 1'b0;
                    ptr_nxt = first_r ? sh_r : ptr_inc_w;
                end
            ST_RACK:
                if (fall_w)
                begin
                    st_nxt = ST_RX;
                    cnt_nxt = CNT_ZERO;
                end
            ST_TX:
                if (fall_w)
                begin
                    if (cnt_r == BIT_COUNT)
                        st_nxt = ST_MACK;
                    else
                        tx_nxt = {tx_r[6:0], 1'b0};
                end
            ST_MACK:
            begin
                if (rise_w)
                    nack_nxt = sda_in;
                if (fall_w)
                begin
                    cnt_nxt = CNT_ZERO;
                    st_nxt = nack_r ? ST_IDLE : ST_TX;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        if (fetch_w)
        begin
            tx_nxt = rd_data;
            ptr_nxt = ptr_inc_w;
        end
        if (start_w)
        begin
            st_nxt = ST_DEV;
            cnt_nxt = CNT_ZERO;
        end
        else if (stop_w)
            st_nxt = ST_IDLE;
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            st_r <= ST_IDLE;
            {scl_q_r, sda_q_r} <= 2'h3;
            {rw_r, first_r, nack_r} <= 3'h0;
            cnt_r <= CNT_ZERO;
            {sh_r, tx_r, ptr_r} <= {REG_RESET, REG_RESET, REG_RESET};
        end
        else if (ce)
        begin
            st_r <= st_nxt;
            {scl_q_r, sda_q_r} <= {scl_in, sda_in};
            {rw_r, first_r, nack_r} <= {rw_nxt, first_nxt, nack_nxt};
            cnt_r <= cnt_nxt;
            {sh_r, tx_r, ptr_r} <= {sh_nxt, tx_nxt, ptr_nxt};
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    addr_ack_a: assert property (
        ce && st_r == ST_DEV && done_w && hit_w && !start_w && !stop_w |=> sda_oe && st_r == ST_DACK)
        else $error("own address not acknowledged");
    auto_incr_a: assert property (
        wr_en |=> reg_addr == $past(reg_addr) + 8'h01)
        else $error("pointer did not step after a write");
endmodule

// ### verilog/ths_regs.sv
// host register bank of the touch controller behind the serial bus slave
`timescale 1ns/100ps
module ths_regs
    import ths_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // interrupt pin
    output logic irq_out_n,
    // sensing engine events
    input wire logic burn_done,
    input wire logic spm_write_done,
    input wire logic touch_event,
    input wire logic release_event,
    input wire logic release_report_en,
    input wire logic comp_done,
    input wire logic mode_entered,
    // sensing engine status
    input wire logic prox_close,
    input wire logic prio_key_touched,
    input wire logic [KEY_COUNT-1:0] key_touch,
    input wire logic nonvolatile_params_valid,
    input wire logic comp_running,
    // controls to the engine
    output logic [1:0] op_mode,
    output logic comp_trigger,
    output logic [7:0] gpo_on,
    output logic [7:0] gw_cfg,
    output logic [7:0] gw_base,
    output logic [7:0] burn_key_high,
    output logic [7:0] burn_key_low,
    output logic soft_restart
);
    logic wr_en, rd_en;
    logic [7:0] reg_addr, wr_data, rd_data;
    logic [7:0] irq_r, irq_nxt, tstat_r, pstat_r;
    logic irq_n_r, mode_pend_r, comp_trig_r, arm_r, restart_r;
    logic [5:0] key_r, key_nxt;
    logic [1:0] mode_r;
    logic [7:0] gpo_r, cfg_r, base_r, khi_r, klo_r, rst_val_r;

    ths_i2c_slave u_slave
    (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .reg_addr(reg_addr),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );

    // write strobes per register
    wire we_mode_w = wr_en & (reg_addr == ADDR_COMP_MODE);
    wire we_gpo_w = wr_en & (reg_addr == ADDR_GPO_CTRL);
    wire we_cfg_w = wr_en & (reg_addr == ADDR_GW_CFG);
    wire we_base_w = wr_en & (reg_addr == ADDR_GW_BASE);
    wire we_khi_w = wr_en & (reg_addr == ADDR_KEY_HIGH);
    wire we_klo_w = wr_en & (reg_addr == ADDR_KEY_LOW);
    wire we_rst_w = wr_en & (reg_addr == ADDR_RESTART);
    wire [1:0] wmode_w = wr_data[1:0];
    wire mode_ok_w = we_mode_w & (wmode_w != MODE_RSVD);
    wire mode_req_w = we_mode_w & ((wmode_w == MODE_ACTIVE) | (wmode_w == MODE_DOZE));

    // event capture, engine pulses already carry the scan-period lag
    wire sense_w = touch_event | (release_event & release_report_en);
    wire mode_hit_w = mode_entered & mode_pend_r;
    wire [7:0] set_w = ((8'(burn_done) << IRQ_BURN_BIT)
        | (8'(spm_write_done) << IRQ_SPMW_BIT)
        | (8'(sense_w) << IRQ_SENSE_BIT)
        | (8'(comp_done) << IRQ_COMP_BIT)
        | (8'(mode_hit_w) << IRQ_MODE_BIT)) & IRQ_USED_MASK;
    wire clr_w = rd_en & (reg_addr == ADDR_IRQ_SRC);
    assign irq_nxt = (clr_w ? REG_RESET : irq_r) | set_w;

    // first touched key stays reported while it is held
    function automatic logic [5:0] lowest_key(input logic [KEY_COUNT-1:0] v);
        logic [5:0] k;
        k = KEY_NONE;
        for (int i = KEY_COUNT - 1; i >= 0; i--)
            if (v[i])
                k = 6'(i + 1);
        return k;
    endfunction

    wire held_w = (key_r != KEY_NONE) && key_touch[key_r - KEY_ONE];
    assign key_nxt = held_w ? key_r : lowest_key(key_touch);

    // read selection, unmapped and reserved addresses read zero
    assign rd_data = (reg_addr == ADDR_IRQ_SRC) ? irq_r
        : (reg_addr == ADDR_TOUCH_STAT) ? tstat_r
        : (reg_addr == ADDR_PMEM_STAT) ? pstat_r
        : (reg_addr == ADDR_COMP_MODE) ? {5'h00, comp_running, mode_r}
        : (reg_addr == ADDR_GPO_CTRL) ? gpo_r
        : (reg_addr == ADDR_GW_CFG) ? cfg_r
        : (reg_addr == ADDR_GW_BASE) ? base_r
        : (reg_addr == ADDR_KEY_HIGH) ? khi_r
        : (reg_addr == ADDR_KEY_LOW) ? klo_r
        : (reg_addr == ADDR_RESTART) ? rst_val_r
        : REG_RESET;

    assign irq_out_n = irq_n_r;
    assign op_mode = mode_r;
    assign comp_trigger = comp_trig_r;
    assign gpo_on = gpo_r;
    assign gw_cfg = cfg_r;
    assign gw_base = base_r;
    assign burn_key_high = khi_r;
    assign burn_key_low = klo_r;
    assign soft_restart = restart_r;

    // interrupt flags and pin
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            irq_r <= REG_RESET;
            irq_n_r <= 1'b1;
        end
        else if (ce)
        begin
            irq_r <= irq_nxt;
            irq_n_r <= ~(|irq_nxt);
        end
    end

    // status registers
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            key_r <= KEY_NONE;
            tstat_r <= REG_RESET;
            pstat_r <= REG_RESET;
        end
        else if (ce)
        begin
            key_r <= key_nxt;
            tstat_r <= {prox_close, prio_key_touched, key_nxt};
            pstat_r <= nonvolatile_params_valid ? PMEM_NVM_VALID : REG_RESET;
        end
    end

    // mode and compensation control
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            mode_r <= MODE_ACTIVE;
            mode_pend_r <= 1'b0;
            comp_trig_r <= 1'b0;
        end
        else if (ce)
        begin
            if (mode_ok_w)
                mode_r <= wmode_w;
            mode_pend_r <= mode_req_w | (mode_pend_r & ~mode_entered);
            comp_trig_r <= we_mode_w & wr_data[COMP_BIT];
        end
    end

    // plain read/write registers and restart sequence
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            {gpo_r, cfg_r, base_r} <= {REG_RESET, REG_RESET, REG_RESET};
            {khi_r, klo_r, rst_val_r} <= {REG_RESET, REG_RESET, REG_RESET};
            arm_r <= 1'b0;
            restart_r <= 1'b0;
        end
        else if (ce)
        begin
            if (we_gpo_w)
                gpo_r <= wr_data;
            if (we_cfg_w)
                cfg_r <= wr_data & GW_CFG_MASK;
            if (we_base_w)
                base_r <= wr_data & GW_BASE_MASK;
            if (we_khi_w)
                khi_r <= wr_data;
            if (we_klo_w)
                klo_r <= wr_data;
            if (we_rst_w)
            begin
                rst_val_r <= wr_data;
                arm_r <= (wr_data == RESTART_ARM);
            end
            restart_r <= we_rst_w & arm_r & (wr_data == RESTART_FIRE);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence clear_read_s;
        ce && clr_w && set_w == REG_RESET;
    endsequence

    sequence mode_ask_s;
        ce && we_mode_w && wmode_w == MODE_DOZE && !mode_entered;
    endsequence

    sequence arm_write_s;
        ce && we_rst_w && wr_data == RESTART_ARM;
    endsequence

    sequence fire_write_s;
        ce && we_rst_w && wr_data == RESTART_FIRE && arm_r;
    endsequence

    burn_flag_a: assert property (ce && burn_done |=> irq_r[IRQ_BURN_BIT])
        else $error("burn flag not set");

    spmw_flag_a: assert property (ce && spm_write_done |=> irq_r[IRQ_SPMW_BIT])
        else $error("shadow write flag not set");

    sense_flag_a: assert property (
        ce && (touch_event || release_event && release_report_en) |=> irq_r[IRQ_SENSE_BIT])
        else $error("sensor flag not set");

    release_gate_a: assert property (
        ce && !clr_w && !irq_r[IRQ_SENSE_BIT] && !touch_event && !release_report_en
        |=> !irq_r[IRQ_SENSE_BIT])
        else $error("sensor flag set by masked release");

    comp_flag_a: assert property (ce && comp_done |=> irq_r[IRQ_COMP_BIT])
        else $error("compensation flag not set");

    mode_unasked_a: assert property (
        ce && !mode_pend_r && !irq_r[IRQ_MODE_BIT] |=> !irq_r[IRQ_MODE_BIT])
        else $error("mode flag set without a host request");

    mode_entry_a: assert property (
        mode_ask_s |=> mode_pend_r && mode_r == MODE_DOZE)
        else $error("requested mode entry not pending");

    mode_flag_a: assert property (ce && mode_pend_r && mode_entered |=> irq_r[IRQ_MODE_BIT])
        else $error("requested mode entry not flagged");

    irq_pin_a: assert property (irq_out_n == !(|irq_r))
        else $error("interrupt pin disagrees with flags");

    flag_keep_a: assert property (
        ce && !clr_w && irq_r[IRQ_COMP_BIT] ##1 ce && !clr_w |=> irq_r[IRQ_COMP_BIT])
        else $error("flag lost before clearing read");

    read_clear_a: assert property (clear_read_s |=> irq_r == REG_RESET && irq_out_n)
        else $error("reading flags did not clear them");

    rsvd_flags_a: assert property ((irq_r & ~IRQ_USED_MASK) == REG_RESET)
        else $error("reserved interrupt bit set");

    prox_stat_a: assert property (ce |=> tstat_r[PROX_BIT] == $past(prox_close))
        else $error("proximity bit wrong");

    prio_stat_a: assert property (ce |=> tstat_r[PRIO_BIT] == $past(prio_key_touched))
        else $error("priority key bit wrong");

    key_range_a: assert property (tstat_r[5:0] <= 6'(KEY_COUNT))
        else $error("matrix key number out of range");

    no_touch_a: assert property (ce && key_touch == '0 |=> tstat_r[5:0] == KEY_NONE)
        else $error("key reported with nothing touched");

    first_key_a: assert property (ce && held_w |=> key_r == $past(key_r))
        else $error("first touched key replaced while held");

    nvm_stat_a: assert property (
        ce |=> pstat_r == ($past(nonvolatile_params_valid) ? PMEM_NVM_VALID : REG_RESET))
        else $error("memory status wrong");

    rsvd_read_a: assert property (
        (reg_addr inside {[8'h02:8'h07], 8'h0b, 8'h0c, 8'h0f}) |-> rd_data == REG_RESET)
        else $error("reserved address read nonzero");

    mode_rsvd_a: assert property (
        ce && we_mode_w && wmode_w == MODE_RSVD |=> mode_r == $past(mode_r))
        else $error("reserved mode code accepted");

    comp_pulse_a: assert property (ce && we_mode_w && wr_data[COMP_BIT] |=> comp_trigger)
        else $error("compensation request not passed on");

    set_wins_a: assert property (ce && clr_w && comp_done |=> irq_r[IRQ_COMP_BIT])
        else $error("event lost in clearing read");

    gpo_write_a: assert property (ce && we_gpo_w |=> gpo_on == $past(wr_data))
        else $error("output control write lost");

    cfg_mask_a: assert property ((gw_cfg & ~GW_CFG_MASK) == REG_RESET)
        else $error("gateway configuration holds reserved bits");

    restart_arm_a: assert property (arm_write_s |=> arm_r)
        else $error("restart not armed");

    restart_seq_a: assert property (
        fire_write_s |=> soft_restart ##1 (!soft_restart || !ce))
        else $error("restart sequence not honoured");

    restart_lone_a: assert property (ce && we_rst_w && !arm_r |=> !soft_restart)
        else $error("restart without arming write");
endmodule

// ### verif/ths_host_model.sv
// serial bus host model: drives the bus clock and pulls data low
`timescale 1ns/100ps
module ths_host_model (
    // clock
    input wire logic clock,
    // bus
    output logic scl,
    output logic sda_pull,
    input wire logic sda_wire
);
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge clock);
    endtask
    task automatic start();
        sda_pull <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_pull <= 1'b1;
        half();
        scl <= 1'b0;
        half();
    endtask
    task automatic stop();
        sda_pull <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_pull <= 1'b0;
        half();
    endtask
    task automatic send_bit(input logic b);
        sda_pull <= !b;
        half();
        scl <= 1'b1;
        half();
        scl <= 1'b0;
        half();
    endtask
    // data line released, sampled while the bus clock is high
    task automatic get_bit(output logic b);
        sda_pull <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        b = sda_wire;
        scl <= 1'b0;
        half();
    endtask
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            send_bit(d[i]);
        get_bit(b);
        ack = !b;
    endtask
    // last byte gets a nack; every earlier byte of the read gets an ack
    task automatic read_byte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--)
            get_bit(d[i]);
        send_bit(last);
    endtask
endmodule

// ### verif/tb_top.sv
// self-checking bench of the touch host status register bank
`timescale 1ns/100ps
module tb_top;
    import ths_pkg::*;
    logic clock, rstn, ce, scl, sda_pull, sda_wire, sda_out, sda_oe, irq_out_n, ack;
    logic rel_en, prox, prio, nvm_ok, comp_run, comp_trigger, soft_restart;
    logic [5:0] ev;
    logic [KEY_COUNT-1:0] keys;
    logic [1:0] op_mode;
    logic [7:0] gpo_on, gw_cfg, gw_base, key_hi, key_lo, d, d2, gv;
    logic [7:0] rq[$];
    logic [7:0] all_a [10] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e, 8'hac, 8'had, 8'hb1};
    logic [7:0] rsv_a [9] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0b, 8'h0c, 8'h0f};
    int num_errors, n_tests, n_restart, n_comp, k1, k2;
    assign sda_wire = (sda_oe ? sda_out : 1'b1) && !sda_pull;
    ths_host_model host (.clock(clock), .scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire));
    ths_regs dut (.clock(clock), .rstn(rstn), .ce(ce), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .irq_out_n(irq_out_n), .burn_done(ev[0]),
        .spm_write_done(ev[1]), .touch_event(ev[2]), .comp_done(ev[3]), .release_event(ev[4]),
        .mode_entered(ev[5]), .release_report_en(rel_en), .prox_close(prox),
        .prio_key_touched(prio), .key_touch(keys), .nonvolatile_params_valid(nvm_ok),
        .comp_running(comp_run), .op_mode(op_mode), .comp_trigger(comp_trigger), .gpo_on(gpo_on),
        .gw_cfg(gw_cfg), .gw_base(gw_base), .burn_key_high(key_hi), .burn_key_low(key_lo),
        .soft_restart(soft_restart));
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock)
    begin
        if (soft_restart === 1'b1)
            n_restart <= n_restart + 1;
        if (comp_trigger === 1'b1)
            n_comp <= n_comp + 1;
    end
    function automatic logic [7:0] mask_of(input logic [7:0] a);
        case (a)
            ADDR_GW_CFG: return GW_CFG_MASK;
            ADDR_GW_BASE: return GW_BASE_MASK;
            ADDR_GPO_CTRL, ADDR_KEY_HIGH, ADDR_KEY_LOW, ADDR_RESTART: return 8'hff;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] out_of(input logic [7:0] a);
        case (a)
            ADDR_GPO_CTRL: return gpo_on;
            ADDR_GW_CFG: return gw_cfg;
            ADDR_GW_BASE: return gw_base;
            ADDR_KEY_HIGH: return key_hi;
            default: return key_lo;
        endcase
    endfunction
    // burn bit 6, shadow write 5, sensor 2, compensation 1
    function automatic logic [7:0] irq_of(input logic [3:0] m);
        return {1'b0, m[0], m[1], 2'b00, m[2], m[3], 1'b0};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v0, input logic [7:0] v1, input int n);
        host.start();
        host.write_byte(8'h56, ack);
        check({7'h0, ack}, 8'h01);
        host.write_byte(a, ack);
        host.write_byte(v0, ack);
        if (n > 1)
            host.write_byte(v1, ack);
        host.stop();
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        logic [7:0] b;
        rq.delete();
        host.start();
        host.write_byte(8'h56, ack);
        host.write_byte(a, ack);
        host.start();
        host.write_byte(8'h57, ack);
        for (int i = 0; i < n; i++)
        begin
            host.read_byte(b, i == n - 1);
            rq.push_back(b);
        end
        host.stop();
    endtask
    task automatic pulse(input logic [5:0] m);
        ev <= m;
        @(posedge clock);
        ev <= '0;
        repeat (2) @(posedge clock);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (100000) @(posedge clock);
        num_errors++;
        end_of_test();
    end
    initial
    begin
        {rstn, ev, rel_en, prox, prio, nvm_ok, comp_run, keys} = '0;
        {num_errors, n_tests, n_restart, n_comp} = '0;
        ce = 1'b1;
        void'($urandom(32'h110a));
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        check({7'h0, irq_out_n}, 8'h01);
        foreach (all_a[i])
        begin
            rd(all_a[i], 1);
            check(rq[0], 8'h00);
        end
        $display("test reset done");
        for (int i = 4; i < 10; i++)
        begin
            d = $urandom;
            wr(all_a[i], d, 8'h00, 1);
            rd(all_a[i], 1);
            check(rq[0], d & mask_of(all_a[i]));
            if (all_a[i] != ADDR_RESTART)
                check(out_of(all_a[i]), d & mask_of(all_a[i]));
            if (all_a[i] == ADDR_GPO_CTRL)
                gv = d;
        end
        d = $urandom;
        d2 = $urandom;
        wr(ADDR_GW_CFG, d, d2, 2);
        rd(ADDR_GW_CFG, 2);
        check(rq[1], d2 & GW_BASE_MASK);
        check(gw_cfg, d & GW_CFG_MASK);
        $display("test read write done");
        foreach (rsv_a[i])
        begin
            wr(rsv_a[i], $urandom, 8'h00, 1);
            rd(rsv_a[i], 1);
            check(rq[0], 8'h00);
        end
        wr(ADDR_PMEM_STAT, 8'hff, 8'h00, 1);
        rd(ADDR_PMEM_STAT, 1);
        check(rq[0], 8'h00);
        $display("test reserved done");
        repeat (6)
        begin
            d = $urandom;
            for (int i = 0; i < 4; i++)
                if (d[i])
                    pulse(6'h01 << i);
            check({7'h0, irq_out_n}, {7'h0, d[3:0] == 4'h0});
            rd(ADDR_IRQ_SRC, 1);
            check(rq[0], irq_of(d[3:0]));
            check({7'h0, irq_out_n}, 8'h01);
        end
        pulse(6'h10);
        rd(ADDR_IRQ_SRC, 1);
        check(rq[0], 8'h00);
        ce <= 1'b0;
        pulse(6'h01);
        ce <= 1'b1;
        rd(ADDR_IRQ_SRC, 1);
        check(rq[0], 8'h00);
        rel_en <= 1'b1;
        pulse(6'h10);
        rd(ADDR_IRQ_SRC, 1);
        check(rq[0], 8'h04);
        $display("test interrupt done");
        pulse(6'h20);
        rd(ADDR_IRQ_SRC, 1);
        check(rq[0], 8'h00);
        wr(ADDR_COMP_MODE, 8'h01, 8'h00, 1);
        check({6'h0, op_mode}, {6'h0, MODE_DOZE});
        pulse(6'h20);
        rd(ADDR_IRQ_SRC, 1);
        check(rq[0], 8'h01);
        wr(ADDR_COMP_MODE, 8'h02, 8'h00, 1);
        pulse(6'h20);
        wr(ADDR_COMP_MODE, 8'h03, 8'h00, 1);
        rd(ADDR_IRQ_SRC, 1);
        check(rq[0], 8'h00);
        check({6'h0, op_mode}, {6'h0, MODE_SLEEP});
        comp_run <= 1'b1;
        wr(ADDR_COMP_MODE, 8'h04, 8'h00, 1);
        pulse(6'h20);
        rd(ADDR_COMP_MODE, 2);
        check(rq[0], 8'h04);
        check(rq[1], gv);
        check(gpo_on, gv);
        rd(ADDR_IRQ_SRC, 1);
        check(rq[0], 8'h01);
        check(n_comp[7:0], 8'h01);
        $display("test mode done");
        prox <= $urandom;
        prio <= $urandom;
        k1 = 1 + $urandom % 36;
        k2 = 1 + (k1 + $urandom % 35) % 36;
        keys[k1 - 1] <= 1'b1;
        rd(ADDR_TOUCH_STAT, 1);
        check(rq[0], {prox, prio, k1[5:0]});
        keys[k2 - 1] <= 1'b1;
        rd(ADDR_TOUCH_STAT, 1);
        check(rq[0][5:0], k1[7:0]);
        keys[k1 - 1] <= 1'b0;
        rd(ADDR_TOUCH_STAT, 1);
        check(rq[0][5:0], k2[7:0]);
        keys <= '0;
        nvm_ok <= 1'b1;
        rd(ADDR_TOUCH_STAT, 8);
        check(rq[0][5:0], KEY_NONE);
        check(rq[7], PMEM_NVM_VALID);
        $display("test status done");
        host.start();
        host.write_byte(8'h50, ack);
        host.stop();
        check({7'h0, ack}, 8'h00);
        wr(ADDR_RESTART, RESTART_ARM, 8'h00, 1);
        wr(ADDR_RESTART, RESTART_FIRE, 8'h00, 1);
        check(n_restart[7:0], 8'h01);
        $display("test bus done");
        end_of_test();
    end
endmodule
